/* rtl/lkeb_emu_buffers.sv */
`timescale 1ns/100ps
module lkeb_emu_buffers (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Memory-side register access
   input wire lkeb_pkg::lkeb_mem_req_s memReq,
   output logic [31:0] memRdata,
   // Emulated I/O cycles
   input wire lkeb_pkg::lkeb_io_req_s ioReq,
   output logic [7:0] ioRdata,
   output logic ioHit,
   // Control bits held elsewhere
   input wire logic emulationOn,
   input wire logic charWaitIrqEn,
   input wire logic legacyIrqEnable,
   // Pin from keyboard inhibit switch (high when not inhibited)
   input wire logic kbdEnablePin,
   // Outputs
   output logic keyboardIrqLine,
   output logic mouseIrqLine,
   output logic emuIrqCond,
   output logic a20GateSeqActive,
   output logic [7:0] inByte
);
   logic [7:0] outByte_r;
   logic [7:0] outByte_nxt;
   logic [7:0] stat_r;
   logic [7:0] stat_nxt;
   logic [7:0] inByte_r;
   logic [7:0] inByte_nxt;
   logic a20_r;
   logic a20_nxt;
   logic kbdIrq_r;
   logic kbdIrq_nxt;
   logic mouseIrq_r;
   logic mouseIrq_nxt;
   logic emuIrq_r;
   logic emuIrq_nxt;
   logic [31:0] memRdata_r;
   logic [31:0] memRdata_nxt;
   logic [7:0] ioRdata_r;
   logic [7:0] ioRdata_nxt;
   logic ioHit_r;
   logic ioHit_nxt;
   logic kbdEnable;

   // Decode of a memory address, used for both read and write paths
   function automatic logic memSel(input logic [11:0] a, input logic [11:0] ofs);
      memSel = (a == ofs);
   endfunction

   // Decode of an emulated port; gated by the enable so ports stay dead otherwise
   function automatic logic portSel(input logic [15:0] p, input logic [15:0] want,
                                    input logic en);
      portSel = en && (p == want);
   endfunction

   lkeb_pin_sync uInhSync (
      .mclk(mclk),
      .rst_b(rst_b),
      .pinIn(kbdEnablePin),
      .pinOut(kbdEnable)
   );

   logic rd60;
   logic rd64;
   logic wr60;
   logic wr64;
   logic a20Write;
   assign rd60 = ioReq.rd && portSel(ioReq.port, lkeb_pkg::PORT_DATA, emulationOn);
   assign rd64 = ioReq.rd && portSel(ioReq.port, lkeb_pkg::PORT_CMD, emulationOn);
   assign wr60 = ioReq.wr && portSel(ioReq.port, lkeb_pkg::PORT_DATA, emulationOn);
   assign wr64 = ioReq.wr && portSel(ioReq.port, lkeb_pkg::PORT_CMD, emulationOn);
   // Data byte following a D1h command is the A20 value; it is not a real input
   assign a20Write = (wr64 && ioReq.wdata == lkeb_pkg::A20_CMD) || (wr60 && a20_r);

   // Register state
   always_comb begin
      outByte_nxt = outByte_r;
      stat_nxt = stat_r;
      inByte_nxt = inByte_r;
      a20_nxt = a20_r;
      // Memory side: plain store, no flag effects
      if (memReq.wr && memSel(memReq.addr, lkeb_pkg::OFS_OUTPUT)) begin
         outByte_nxt = memReq.wdata[7:0];
      end
      if (memReq.wr && memSel(memReq.addr, lkeb_pkg::OFS_STATUS)) begin
         stat_nxt = memReq.wdata[7:0];
      end
      if (memReq.wr && memSel(memReq.addr, lkeb_pkg::OFS_INPUT)) begin
         inByte_nxt = memReq.wdata[7:0];
      end
      // I/O side effects apply after the memory write, so a same-cycle port event wins
      if (rd60) begin
         stat_nxt[lkeb_pkg::ST_OBF] = 1'b0;
      end
      if (wr60 || wr64) begin
         inByte_nxt = ioReq.wdata;
         if (!a20Write) begin
            stat_nxt[lkeb_pkg::ST_IBF] = 1'b1;
         end
         stat_nxt[lkeb_pkg::ST_CMD] = wr64;
      end
      if (wr64) begin
         a20_nxt = (ioReq.wdata == lkeb_pkg::A20_CMD);
      end
      // Inhibit bit is hardware-owned; software writes to it do not stick
      stat_nxt[lkeb_pkg::ST_INH] = kbdEnable;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         outByte_r <= lkeb_pkg::OUT_RST;
         stat_r <= lkeb_pkg::STAT_RST;
         inByte_r <= 8'h00;
         a20_r <= 1'b0;
      end else begin
         outByte_r <= outByte_nxt;
         stat_r <= stat_nxt;
         inByte_r <= inByte_nxt;
         a20_r <= a20_nxt;
      end
   end

   // Interrupts and read data, all registered so outputs come from flops
   always_comb begin
      kbdIrq_nxt = legacyIrqEnable && !stat_nxt[lkeb_pkg::ST_AUX]
         && stat_nxt[lkeb_pkg::ST_OBF];
      mouseIrq_nxt = legacyIrqEnable && stat_nxt[lkeb_pkg::ST_AUX]
         && stat_nxt[lkeb_pkg::ST_OBF];
      emuIrq_nxt = (charWaitIrqEn && !stat_nxt[lkeb_pkg::ST_OBF])
         || (emulationOn && stat_nxt[lkeb_pkg::ST_IBF]);
      memRdata_nxt = 32'h0000_0000;
      if (memReq.rd) begin
         if (memSel(memReq.addr, lkeb_pkg::OFS_OUTPUT)) begin
            memRdata_nxt = {24'h00_0000, outByte_r};
         end else if (memSel(memReq.addr, lkeb_pkg::OFS_STATUS)) begin
            memRdata_nxt = {24'h00_0000, stat_r};
         end else if (memSel(memReq.addr, lkeb_pkg::OFS_INPUT)) begin
            memRdata_nxt = {24'h00_0000, inByte_r};
         end
      end
      ioRdata_nxt = 8'h00;
      ioHit_nxt = rd60 || rd64;
      if (rd60) begin
         ioRdata_nxt = outByte_r;
      end else if (rd64) begin
         ioRdata_nxt = stat_r;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         kbdIrq_r <= 1'b0;
         mouseIrq_r <= 1'b0;
         emuIrq_r <= 1'b0;
         memRdata_r <= 32'h0000_0000;
         ioRdata_r <= 8'h00;
         ioHit_r <= 1'b0;
      end else begin
         kbdIrq_r <= kbdIrq_nxt;
         mouseIrq_r <= mouseIrq_nxt;
         emuIrq_r <= emuIrq_nxt;
         memRdata_r <= memRdata_nxt;
         ioRdata_r <= ioRdata_nxt;
         ioHit_r <= ioHit_nxt;
      end
   end

   assign keyboardIrqLine = kbdIrq_r;
   assign mouseIrqLine = mouseIrq_r;
   assign emuIrqCond = emuIrq_r;
   assign a20GateSeqActive = a20_r;
   assign inByte = inByte_r;
   assign memRdata = memRdata_r;
   assign ioRdata = ioRdata_r;
   assign ioHit = ioHit_r;
endmodule // lkeb_emu_buffers

/* rtl/lkeb_pin_sync.sv */
`timescale 1ns/100ps
// Three-stage synchroniser; output changes once stages two and three agree
module lkeb_pin_sync (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Pin and result
   input wire logic pinIn,
   output logic pinOut
);
   logic [2:0] sh_r;
   logic [2:0] sh_nxt;
   logic val_r;
   logic val_nxt;

   always_comb begin
      sh_nxt = {sh_r[1:0], pinIn};
      val_nxt = (sh_r[2] == sh_r[1]) ? sh_r[2] : val_r;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sh_r <= 3'h0;
         val_r <= 1'b0;
      end else begin
         sh_r <= sh_nxt;
         val_r <= val_nxt;
      end
   end

   assign pinOut = val_r;
endmodule // lkeb_pin_sync

/* rtl/lkeb_pkg.sv */
package lkeb_pkg;
   // Operational register offsets (byte addresses, memory side)
   localparam logic [11:0] OFS_CONTROL = 12'h100;
   localparam logic [11:0] OFS_INPUT = 12'h104;
   localparam logic [11:0] OFS_OUTPUT = 12'h108;
   localparam logic [11:0] OFS_STATUS = 12'h10c;
   // Emulated I/O ports
   localparam logic [15:0] PORT_DATA = 16'h0060;
   localparam logic [15:0] PORT_CMD = 16'h0064;
   localparam logic [7:0] A20_CMD = 8'hd1;
   // Status field positions
   localparam int ST_OBF = 0;
   localparam int ST_IBF = 1;
   localparam int ST_FLAG = 2;
   localparam int ST_CMD = 3;
   localparam int ST_INH = 4;
   localparam int ST_AUX = 5;
   localparam int ST_TMO = 6;
   localparam int ST_PAR = 7;
   // Control field positions
   localparam int CT_EMU = 0;
   localparam int CT_EINT = 1;
   localparam int CT_CHAR = 2;
   localparam int CT_LEGACY_IRQ_ENABLE = 3;
   localparam int CT_A20 = 5;
   // Reset values
   localparam logic [7:0] OUT_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } lkeb_mem_req_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] port;
      logic [7:0] wdata;
   } lkeb_io_req_s;
endpackage

/* sim/lkeb_emu_buffers_properties.sv */
`timescale 1ns/100ps
module lkeb_emu_buffers_properties (
   // Clock, reset and inputs
   input wire logic mclk,
   input wire logic rst_b,
   input wire lkeb_pkg::lkeb_io_req_s ioReq,
   input wire logic emulationOn,
   // Outputs
   input wire logic [7:0] ioRdata,
   input wire logic ioHit,
   input wire logic keyboardIrqLine,
   input wire logic mouseIrqLine,
   input wire logic emuIrqCond,
   input wire logic a20GateSeqActive
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   wire logic rd = ioReq.rd && emulationOn;
   wire logic wr = ioReq.wr && emulationOn;
   wire logic p60 = ioReq.port == lkeb_pkg::PORT_DATA;
   wire logic p64 = ioReq.port == lkeb_pkg::PORT_CMD;
   wire logic gA20 = ioReq.wdata == lkeb_pkg::A20_CMD;
   sequence s_dataWr;
      wr && p60 && !a20GateSeqActive;
   endsequence
   property p_excl; !(keyboardIrqLine && mouseIrqLine); endproperty
   a_excl: assert property (p_excl) else $error("both irq lines");
   property p_rdClr; rd && p60 |=> !keyboardIrqLine && !mouseIrqLine; endproperty
   a_rdClr: assert property (p_rdClr) else $error("irq after read");
   property p_hit; rd && (p60 || p64) |=> ioHit; endproperty
   a_hit: assert property (p_hit) else $error("read missed");
   property p_noHit; !(rd && (p60 || p64)) |=> !ioHit && ioRdata == 8'h00; endproperty
   a_noHit: assert property (p_noHit) else $error("stray read");
   property p_a20On; wr && p64 && gA20 |=> a20GateSeqActive; endproperty
   a_a20On: assert property (p_a20On) else $error("a20 not set");
   property p_a20Off; wr && p64 && !gA20 |=> !a20GateSeqActive; endproperty
   a_a20Off: assert property (p_a20Off) else $error("a20 not cleared");
   property p_a20Hold; !(wr && p64) |=> $stable(a20GateSeqActive); endproperty
   a_a20Hold: assert property (p_a20Hold) else $error("a20 moved");
   property p_ibf; s_dataWr ##1 emulationOn |-> emuIrqCond; endproperty
   a_ibf: assert property (p_ibf) else $error("no emulation irq");
endmodule // lkeb_emu_buffers_properties

bind lkeb_emu_buffers lkeb_emu_buffers_properties lkeb_emu_buffers_properties_i (.mclk,
   .rst_b, .ioReq, .emulationOn, .ioRdata, .ioHit, .keyboardIrqLine, .mouseIrqLine,
   .emuIrqCond, .a20GateSeqActive);

/* sim/lkeb_host_model.sv */
`timescale 1ns/100ps
module lkeb_host_model (
   // Clock and port cycles
   input wire logic mclk,
   output lkeb_pkg::lkeb_io_req_s ioReq
);
   initial ioReq = '0;
   // Released fields show inverted values so stale data cannot pass for a match
   task automatic cyc(input logic wr, input logic [15:0] port, input logic [7:0] d);
      @(negedge mclk);
      ioReq = '{~wr, wr, port, d};
      @(negedge mclk);
      ioReq = '{1'b0, 1'b0, ~port, ~d};
   endtask
endmodule // lkeb_host_model

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic emulationOn = 1'b1;
   logic charWaitIrqEn = 1'b0;
   logic legacyIrqEnable = 1'b1;
   logic kbdEnablePin = 1'b1;
   lkeb_pkg::lkeb_mem_req_s memReq = '0;
   lkeb_pkg::lkeb_io_req_s ioReq;
   logic [31:0] memRdata;
   logic [7:0] ioRdata;
   logic ioHit, keyboardIrqLine, mouseIrqLine, emuIrqCond, a20GateSeqActive;
   logic [7:0] inByte;
   int errors = 0;
   int cmp_count = 0;
   // Kind (0 mem rd, 1 mem wr, 2 io rd, 3 io wr), address, data or expected, irq lines
   logic [51:0] rows [17] = '{
      52'h0_10c_00000010_0, 52'h1_108_ffffff5a_0, 52'h1_10c_ffff0021_1,
      52'h0_108_0000005a_1, 52'h2_064_00000031_1, 52'h2_060_0000005a_0,
      52'h1_10c_00000001_2, 52'h3_060_00000033_2, 52'h2_064_00000013_2,
      52'h1_10c_00000001_2, 52'h3_064_000000d1_2, 52'h3_060_00000077_2,
      52'h2_064_00000011_2, 52'h3_064_000000aa_2, 52'h2_064_0000001b_2,
      52'h0_104_000000aa_2, 52'h0_200_00000000_2};
   always #5 mclk = ~mclk;
   lkeb_host_model lkeb_host_model_i (.mclk, .ioReq);
   lkeb_emu_buffers lkeb_emu_buffers_i (.mclk, .rst_b, .memReq, .memRdata, .ioReq,
      .ioRdata, .ioHit, .emulationOn, .charWaitIrqEn, .legacyIrqEnable, .kbdEnablePin,
      .keyboardIrqLine, .mouseIrqLine, .emuIrqCond, .a20GateSeqActive, .inByte);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic op(input logic [51:0] r);
      if (r[49]) begin
         lkeb_host_model_i.cyc(r[48], {4'h0, r[47:36]}, r[11:4]);
      end else begin
         @(negedge mclk);
         memReq = '{~r[48], r[48], r[47:36], r[35:4]};
         @(negedge mclk);
         memReq = '{1'b0, 1'b0, ~r[47:36], ~r[35:4]};
      end
      if (r[51:48] == 4'h2) chk({23'h0, ioHit, ioRdata}, {23'h0, emulationOn, r[11:4]});
      if (r[51:48] == 4'h0) chk(memRdata, r[35:4]);
      chk({30'h0, keyboardIrqLine, mouseIrqLine}, {28'h0, r[3:0]});
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      // Let the inhibit pin synchroniser settle first
      repeat (5) @(negedge mclk);
      foreach (rows[i]) op(rows[i]);
      $display("Table test done");
      chk({31'h0, emuIrqCond}, 32'h1);
      chk({24'h0, inByte}, 32'h0000_00aa);
      chk({31'h0, a20GateSeqActive}, 32'h0);
      emulationOn = 1'b0;
      legacyIrqEnable = 1'b0;
      op(52'h2_060_00000000_0);
      chk({31'h0, emuIrqCond}, 32'h0);
      charWaitIrqEn = 1'b1;
      op(52'h1_10c_00000000_0);
      @(negedge mclk);
      chk({31'h0, emuIrqCond}, 32'h1);
      $display("Emulation irq test done");
      kbdEnablePin = 1'b0;
      repeat (6) @(negedge mclk);
      op(52'h0_10c_00000000_0);
      rst_b = 1'b0;
      @(negedge mclk);
      rst_b = 1'b1;
      op(52'h0_108_00000000_0);
      op(52'h0_10c_00000000_0);
      $display("Reset test done");
      test_done();
   end
endmodule // tb_top
